// ---- shared/spdma_pkg.sv ----
package spdma_pkg;
   // Port 0 offsets from the first base address; each later port is one stride up
   localparam logic [11:0] SPDMA_CMD_OFS = 12'h270;
   localparam logic [11:0] SPDMA_STS_OFS = 12'h272;
   localparam logic [11:0] SPDMA_PORT_STRIDE = 12'h200;
   localparam int SPDMA_CMD_DIR_BIT = 3;
   localparam int SPDMA_CMD_START_BIT = 0;
   localparam int SPDMA_STS_SIMPLEX_BIT = 7;
   localparam int SPDMA_STS_CAPABLE_BIT = 5;
   localparam int SPDMA_STS_INT_BIT = 2;
   localparam int SPDMA_STS_ERR_BIT = 1;
   localparam int SPDMA_STS_ACTIVE_BIT = 0;
   localparam logic SPDMA_CMD_DIR_RST = 1'b0;
   localparam logic SPDMA_CMD_START_RST = 1'b0;
   localparam logic SPDMA_STS_CAPABLE_RST = 1'b1;
   localparam int SPDMA_DATA_W = 32;
   localparam int SPDMA_FIFO_DEPTH = 8;

   typedef enum logic [0:0] {
      SPDMA_IDLE = 1'b0,
      SPDMA_RUN = 1'b1
   } spdma_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } spdma_reg_req_s;

   typedef struct packed {
      logic valid;
      logic [15:0] rdata;
   } spdma_reg_rsp_s;
endpackage : spdma_pkg

// ---- rtl/spdma_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module spdma_fifo
   import spdma_pkg::*;
#(
   parameter int W = 32,
   parameter int DEPTH = 8
)(
   input wire logic clock,
   input wire logic srst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } spdma_fifo_s;

   spdma_fifo_s s_r, s_nxt;
   logic push, pop;

   assign in_ready = (s_r.cnt != FULL);
   assign out_valid = (s_r.cnt != '0);
   assign out_data = s_r.mem[s_r.rp];
   assign count = s_r.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
      end
      if (pop)
         s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
      if (push && !pop)
         s_nxt.cnt = s_r.cnt + 1'b1;
      else if (pop && !push)
         s_nxt.cnt = s_r.cnt - 1'b1;
      // Abort discards everything buffered
      if (flush)
      begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule : spdma_fifo
`default_nettype wire

// ---- rtl/spdma_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module spdma_ctrl
   import spdma_pkg::*;
#(
   parameter logic [1:0] PORT = 2'h0,
   parameter int DATA_W = SPDMA_DATA_W,
   parameter int DEPTH = SPDMA_FIFO_DEPTH
)(
   input wire logic clock,
   input wire logic srst,
   input wire spdma_reg_req_s reg_req,
   output spdma_reg_rsp_s reg_rsp,
   input wire logic mem_rd_valid,
   input wire logic [DATA_W-1:0] mem_rd_data,
   output logic mem_rd_ready,
   output logic sata_tx_valid,
   output logic [DATA_W-1:0] sata_tx_data,
   input wire logic sata_tx_ready,
   input wire logic sata_rx_valid,
   input wire logic [DATA_W-1:0] sata_rx_data,
   output logic sata_rx_ready,
   output logic mem_wr_valid,
   output logic [DATA_W-1:0] mem_wr_data,
   input wire logic mem_wr_ready,
   input wire logic end_of_table_flag,
   input wire logic dev_irq,
   input wire logic pci_err,
   output logic dma_active,
   output logic xfer_dir
);
   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [11:0] CMD_ADDR = SPDMA_CMD_OFS + SPDMA_PORT_STRIDE * 12'(PORT);
   localparam logic [11:0] STS_ADDR = SPDMA_STS_OFS + SPDMA_PORT_STRIDE * 12'(PORT);
   // Ready is registered, so leave one slot for the beat already in flight
   localparam logic [CW-1:0] HI_MARK = CW'(DEPTH - 1);

   typedef struct packed {
      spdma_state_e state;
      logic cmd_dir;
      logic cmd_start;
      logic dir_lat;
      logic capable;
      logic intr;
      logic err;
      logic mem_rdy;
      logic rx_rdy;
      logic tx_v;
      logic [DATA_W-1:0] tx_d;
      logic wr_v;
      logic [DATA_W-1:0] wr_d;
      spdma_reg_rsp_s rsp;
   } spdma_ctrl_s;

   spdma_ctrl_s s_r, s_nxt;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
   logic [DATA_W-1:0] f_in_data, f_out_data;
   logic [CW-1:0] f_cnt;
   logic run, cmd_wr, sts_wr, drained;

   assign run = (s_r.state == SPDMA_RUN);
   assign cmd_wr = reg_req.wr && (reg_req.addr == CMD_ADDR);
   assign sts_wr = reg_req.wr && (reg_req.addr == STS_ADDR);
   // Interrupt waits until no beat is left in the FIFO or an output stage
   assign drained = (f_cnt == '0) && !s_r.tx_v && !s_r.wr_v;

   spdma_fifo #(
      .W(DATA_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .srst(srst),
      .flush(f_flush),
      .in_valid(f_in_valid),
      .in_data(f_in_data),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out_data),
      .out_ready(f_out_ready),
      .count(f_cnt)
   );

   always_comb
   begin
      s_nxt = s_r;
      f_flush = 1'b0;
      if (s_r.dir_lat)
      begin
         f_in_valid = run && sata_rx_valid && s_r.rx_rdy && f_in_ready;
         f_in_data = sata_rx_data;
         f_out_ready = run && (!s_r.wr_v || mem_wr_ready);
      end
      else
      begin
         f_in_valid = run && mem_rd_valid && s_r.mem_rdy && f_in_ready;
         f_in_data = mem_rd_data;
         f_out_ready = run && (!s_r.tx_v || sata_tx_ready);
      end
      // Output stages hold a beat until the far side takes it or a stop or a start from idle clears it
      if (s_r.tx_v && sata_tx_ready)
         s_nxt.tx_v = 1'b0;
      if (s_r.wr_v && mem_wr_ready)
         s_nxt.wr_v = 1'b0;
      if (f_out_valid && f_out_ready)
      begin
         if (s_r.dir_lat)
         begin
            s_nxt.wr_v = 1'b1;
            s_nxt.wr_d = f_out_data;
         end
         else
         begin
            s_nxt.tx_v = 1'b1;
            s_nxt.tx_d = f_out_data;
         end
      end

      // end of table completes the transfer
      if (run && end_of_table_flag)
         s_nxt.state = SPDMA_IDLE;

      if (cmd_wr)
      begin
         if (!run)
            s_nxt.cmd_dir = reg_req.wdata[SPDMA_CMD_DIR_BIT];
         s_nxt.cmd_start = reg_req.wdata[SPDMA_CMD_START_BIT];
         if (!reg_req.wdata[SPDMA_CMD_START_BIT])
         begin
            // buffered beats are discarded, not delivered
            s_nxt.state = SPDMA_IDLE;
            s_nxt.tx_v = 1'b0;
            s_nxt.wr_v = 1'b0;
            f_flush = 1'b1;
         end
         else if (!run)
         begin
            s_nxt.state = SPDMA_RUN;
            s_nxt.dir_lat = reg_req.wdata[SPDMA_CMD_DIR_BIT];
            // A new run never inherits beats left over from a halted one
            s_nxt.tx_v = 1'b0;
            s_nxt.wr_v = 1'b0;
            f_flush = 1'b1;
         end
         // start while running leaves the transfer as it is
      end

      if (sts_wr)
      begin
         // Capable is a plain software flag with no effect on the engine
         s_nxt.capable = reg_req.wdata[SPDMA_STS_CAPABLE_BIT];
         if (reg_req.wdata[SPDMA_STS_INT_BIT])
            s_nxt.intr = 1'b0;
         if (reg_req.wdata[SPDMA_STS_ERR_BIT])
            s_nxt.err = 1'b0;
      end
      // set after all data moved; set beats the clear
      if (dev_irq && drained)
         s_nxt.intr = 1'b1;
      // Error only counts while the engine is moving data
      if (run && pci_err)
         s_nxt.err = 1'b1;

      // Readies follow the next state so a stop closes them at the same edge
      s_nxt.mem_rdy = (s_nxt.state == SPDMA_RUN) && !s_nxt.dir_lat && (f_cnt < HI_MARK)
                      && !f_flush;
      s_nxt.rx_rdy = (s_nxt.state == SPDMA_RUN) && s_nxt.dir_lat && (f_cnt < HI_MARK)
                     && !f_flush;

      // Reads report the state before any write taken at the same edge
      s_nxt.rsp.valid = reg_req.rd;
      s_nxt.rsp.rdata = '0;
      if (reg_req.rd && reg_req.addr == CMD_ADDR)
      begin
         s_nxt.rsp.rdata[SPDMA_CMD_DIR_BIT] = s_r.cmd_dir;
         s_nxt.rsp.rdata[SPDMA_CMD_START_BIT] = s_r.cmd_start;
      end
      else if (reg_req.rd && reg_req.addr == STS_ADDR)
      begin
         s_nxt.rsp.rdata[SPDMA_STS_SIMPLEX_BIT] = 1'b0;
         s_nxt.rsp.rdata[SPDMA_STS_CAPABLE_BIT] = s_r.capable;
         s_nxt.rsp.rdata[SPDMA_STS_INT_BIT] = s_r.intr;
         s_nxt.rsp.rdata[SPDMA_STS_ERR_BIT] = s_r.err;
         s_nxt.rsp.rdata[SPDMA_STS_ACTIVE_BIT] = run;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_r <= '0;
         s_r.state <= SPDMA_IDLE;
         s_r.cmd_dir <= SPDMA_CMD_DIR_RST;
         s_r.cmd_start <= SPDMA_CMD_START_RST;
         s_r.capable <= SPDMA_STS_CAPABLE_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign reg_rsp = s_r.rsp;
   assign mem_rd_ready = s_r.mem_rdy;
   assign sata_rx_ready = s_r.rx_rdy;
   assign sata_tx_valid = s_r.tx_v;
   assign sata_tx_data = s_r.tx_d;
   assign mem_wr_valid = s_r.wr_v;
   assign mem_wr_data = s_r.wr_d;
   assign dma_active = run;
   assign xfer_dir = s_r.dir_lat;

   // Checks sleep through reset and sample on the rising edge
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   chk_simplex_zero: assert property (
      $past(reg_req.rd && reg_req.addr == STS_ADDR) |-> reg_rsp.valid && !reg_rsp.rdata[7]
      && reg_rsp.rdata[0] == $past(run))
      else $error("status read shows simplex bit or wrong active");
   chk_cmd_reserved: assert property (
      $past(reg_req.rd && reg_req.addr == CMD_ADDR) |-> reg_rsp.rdata[15:4] == 12'h000
      && reg_rsp.rdata[2:1] == 2'h0)
      else $error("reserved command bits not zero");
   chk_dir_frozen: assert property (
      run && cmd_wr |=> s_r.cmd_dir == $past(s_r.cmd_dir))
      else $error("direction changed during transfer");
   chk_dir_writable: assert property (
      !run && cmd_wr |=> s_r.cmd_dir == $past(reg_req.wdata[3]))
      else $error("direction not written while idle");
   chk_start_latch: assert property (
      !run && cmd_wr && reg_req.wdata[0] |=> dma_active && xfer_dir == $past(reg_req.wdata[3])
      ##1 (xfer_dir == $past(xfer_dir)))
      else $error("start did not latch direction");
   chk_restart_none: assert property (
      run && cmd_wr && reg_req.wdata[0] && !end_of_table_flag |=> dma_active && $stable(xfer_dir))
      else $error("start while active disturbed transfer");
   chk_stop_abort: assert property (
      run && cmd_wr && !reg_req.wdata[0] |=> !dma_active && f_cnt == '0 && !sata_tx_valid
      && !mem_wr_valid && !mem_rd_ready && !sata_rx_ready)
      else $error("stop did not discard transfer");
   chk_eot_done: assert property (
      run && end_of_table_flag |=> !dma_active)
      else $error("active stayed set after end of table");
   chk_route_dir: assert property (
      (sata_tx_valid |-> !xfer_dir) and (mem_wr_valid |-> xfer_dir) and (mem_rd_ready |-> !xfer_dir)
      and (sata_rx_ready |-> xfer_dir))
      else $error("data routed against direction");
   chk_int_set: assert property (
      dev_irq && drained |=> s_r.intr)
      else $error("interrupt status not set");
   chk_int_clear: assert property (
      s_r.intr && sts_wr && reg_req.wdata[2] && !(dev_irq && drained) |=> !s_r.intr)
      else $error("interrupt status not cleared by write one");
   chk_int_wait: assert property (
      !s_r.intr && !(dev_irq && drained) |=> !s_r.intr)
      else $error("interrupt status set before data moved");

   chk_fill_source: assert property (
      f_in_valid |-> (xfer_dir ? sata_rx_valid && sata_rx_ready : mem_rd_valid && mem_rd_ready))
      else $error("fifo filled from the wrong side");
   chk_tx_hold: assert property (
      sata_tx_valid && !sata_tx_ready && !cmd_wr |=> sata_tx_valid && $stable(sata_tx_data))
      else $error("beat to drive dropped before it was taken");
   chk_wr_hold: assert property (
      mem_wr_valid && !mem_wr_ready && !cmd_wr |=> mem_wr_valid && $stable(mem_wr_data))
      else $error("beat to memory dropped before it was taken");
   chk_idle_quiet: assert property (
      !dma_active |-> !mem_rd_ready && !sata_rx_ready)
      else $error("ready raised while no transfer runs");

   cov_start: cover property (!run && cmd_wr && reg_req.wdata[0] ##1 run);
   cov_abort: cover property (run && f_cnt != '0 && cmd_wr && !reg_req.wdata[0]);
   cov_fifo_full: cover property (f_cnt == CW'(DEPTH));
   cov_eot_irq: cover property (run && end_of_table_flag ##[1:20] s_r.intr);
   cov_restart_held: cover property (run && cmd_wr && reg_req.wdata[0]);
endmodule : spdma_ctrl
`default_nettype wire

// ---- tb/spdma_drive_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module spdma_drive_model (
   input wire logic clock,
   input wire logic srst,
   input wire logic stall,
   input wire logic rx_load,
   input wire logic [7:0] rx_beats,
   input wire logic [31:0] rx_base,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [31:0] rx_data,
   output logic tx_ready
);
   logic [7:0] left_r;
   logic [31:0] next_r;
   logic [3:0] tick_r;
   // A slow drive offers and takes beats only on some cycles
   always_ff @(posedge clock)
   begin
      tick_r <= srst ? 4'h0 : tick_r + 4'h1;
      tx_ready <= !srst && (!stall || tick_r[1]);
      if (srst || rx_load)
      begin
         left_r <= srst ? 8'h00 : rx_beats;
         next_r <= rx_base;
         rx_valid <= 1'b0;
      end
      else if (rx_valid && rx_ready)
      begin
         // Released data turns over so a stale word never matches
         rx_valid <= 1'b0;
         rx_data <= ~rx_data;
         next_r <= next_r + 32'h1;
      end
      else if (!rx_valid && left_r != 8'h00 && (!stall || tick_r[0]))
      begin
         rx_valid <= 1'b1;
         rx_data <= next_r;
         left_r <= left_r - 8'h01;
      end
   end
endmodule : spdma_drive_model
`default_nettype wire

// ---- tb/spdma_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module spdma_ctrl_tb;
   import spdma_pkg::*;
   logic clock = 0;
   logic srst = 1;
   spdma_reg_req_s reg_req = '0;
   spdma_reg_rsp_s reg_rsp;
   logic mem_rd_valid = 0, mem_wr_ready = 0, end_of_table_flag = 0, dev_irq = 0, pci_err = 0;
   logic rx_load = 0, stall = 0, wr_hold = 0;
   logic [31:0] mem_rd_data = '0, rx_base = '0, r, mem_wr_data, sata_tx_data, sata_rx_data;
   logic [7:0] rx_beats = '0;
   logic mem_rd_ready, sata_tx_valid, sata_tx_ready, sata_rx_valid, sata_rx_ready;
   logic mem_wr_valid, dma_active, xfer_dir;
   logic [31:0] seed = 32'h00010CCB;
   logic [31:0] q[$];
   int errors = 0;
   int comparisons = 0;
   always #5 clock = ~clock;
   spdma_ctrl i_dut (.clock(clock), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp),
      .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_rd_ready(mem_rd_ready),
      .sata_tx_valid(sata_tx_valid), .sata_tx_data(sata_tx_data),
      .sata_tx_ready(sata_tx_ready), .sata_rx_valid(sata_rx_valid),
      .sata_rx_data(sata_rx_data), .sata_rx_ready(sata_rx_ready),
      .mem_wr_valid(mem_wr_valid), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
      .end_of_table_flag(end_of_table_flag), .dev_irq(dev_irq), .pci_err(pci_err),
      .dma_active(dma_active), .xfer_dir(xfer_dir));
   spdma_drive_model i_drive (.clock(clock), .srst(srst), .stall(stall), .rx_load(rx_load),
      .rx_beats(rx_beats), .rx_base(rx_base), .rx_ready(sata_rx_ready),
      .rx_valid(sata_rx_valid), .rx_data(sata_rx_data), .tx_ready(sata_tx_ready));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic take(input logic [31:0] v);
      logic [31:0] e;
      e = (q.size() != 0) ? q.pop_front() : ~v;
      `CHK(v, e)
   endtask : take
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(negedge clock);
      reg_req = '{1'b1, 1'b0, a, d};
      @(negedge clock);
      reg_req = '0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      q.push_back({16'h0000, e});
      @(negedge clock);
      reg_req = '{1'b0, 1'b1, a, 16'h0000};
      @(negedge clock);
      reg_req = '0;
   endtask : rd
   task automatic send(input int n);
      logic [31:0] d;
      repeat (n)
      begin
         d = xs();
         @(negedge clock);
         mem_rd_valid = 1;
         mem_rd_data = d;
         do @(posedge clock); while (mem_rd_ready !== 1'b1);
         q.push_back(d);
      end
      @(negedge clock);
      mem_rd_valid = 0;
      mem_rd_data = ~d;
   endtask : send
   task automatic load_rx(input logic [7:0] n);
      @(negedge clock);
      rx_beats = n;
      rx_base = xs();
      rx_load = 1;
      for (int i = 0; i < n; i++)
         q.push_back(rx_base + 32'(i));
      @(negedge clock);
      rx_load = 0;
   endtask : load_rx
   task automatic drain;
      repeat (300) if (q.size() != 0) @(negedge clock);
      `CHK(32'(q.size()), 32'h0)
   endtask : drain
   always @(negedge clock)
   begin
      r = xs();
      mem_wr_ready = !wr_hold && r[0];
   end
   always @(posedge clock)
   begin
      if (!srst && reg_rsp.valid === 1'b1) take({16'h0000, reg_rsp.rdata});
      if (sata_tx_valid === 1'b1 && sata_tx_ready === 1'b1) take(sata_tx_data);
      if (mem_wr_valid === 1'b1 && mem_wr_ready) take(mem_wr_data);
   end
   initial
   begin
      repeat (20) @(negedge clock);
      srst = 0;
      rd(12'h272, 16'h0020);
      rd(12'h472, 16'h0000);
      wr(12'h270, 16'hFFF0);
      rd(12'h270, 16'h0000);
      stall = 1;
      wr(12'h270, 16'h0001);
      wr(12'h270, 16'h0009);
      `CHK(xfer_dir, 1'b0)
      send(12);
      drain;
      rd(12'h270, 16'h0001);
      rd(12'h272, 16'h0021);
      drain;
      @(negedge clock);
      end_of_table_flag = 1;
      @(negedge clock);
      end_of_table_flag = 0;
      `CHK(dma_active, 1'b0)
      wr(12'h270, 16'h0008);
      rd(12'h270, 16'h0008);
      wr(12'h270, 16'h0009);
      `CHK(xfer_dir, 1'b1)
      load_rx(8'd10);
      drain;
      dev_irq = 1;
      pci_err = 1;
      @(negedge clock);
      pci_err = 0;
      repeat (2) @(negedge clock);
      dev_irq = 0;
      rd(12'h272, 16'h0027);
      wr(12'h272, 16'h0026);
      rd(12'h272, 16'h0021);
      drain;
      // Stop with drive data still buffered, against the usage advice
      wr_hold = 1;
      @(negedge clock);
      rx_beats = 8'd6;
      rx_base = xs();
      rx_load = 1;
      @(negedge clock);
      rx_load = 0;
      repeat (40) @(negedge clock);
      `CHK(mem_wr_valid, 1'b1)
      wr(12'h270, 16'h0000);
      `CHK({dma_active, mem_wr_valid, sata_rx_ready}, 3'b000)
      load_rx(8'd0);
      wr_hold = 0;
      wr(12'h270, 16'h0009);
      repeat (30) @(negedge clock);
      rd(12'h272, 16'h0021);
      drain;
      finish_test;
   end
   // Roughly a hundred times the expected run length
   initial
   begin
      #300000;
      errors++;
      finish_test;
   end
endmodule : spdma_ctrl_tb
`default_nettype wire
